//--- logic/tssc_pkg.sv
// Purpose: shared constants for the timer start and lockstep control block
// Assumes: 32-bit register bus, five channels of 16-bit counters
// Notes:   one aligned word per register, control bits in the low byte

// =====================================================================
// package
package tssc_pkg;
	localparam int          NUM_CH       = 5;
	localparam int          CNT_W        = 16;
	localparam int          ADDR_W       = 8;

	// register byte offsets
	localparam logic [7:0]  OFF_START    = 8'h00;
	localparam logic [7:0]  OFF_SYNC     = 8'h04;

	// reset values, reserved pattern and field layout
	localparam logic [7:0]  START_RESET  = 8'hE0;
	localparam logic [7:0]  SYNC_RESET   = 8'hE0;
	localparam logic [7:0]  RSVD_ONES    = 8'hE0;
	localparam int          CH_LSB       = 0;

	// bus response codes
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// register selection
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_START,
		SEL_SYNC
	} tssc_sel_t;
endpackage : tssc_pkg

//--- logic/tssc_chan_if.sv
// Purpose: carrier between the control top and the lockstep fan-out
// Assumes: all signals on sys_clk
// Notes:   fan side registers everything it drives

`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// channel carrier
interface tssc_chan_if
	import tssc_pkg::*;
();
	logic [NUM_CH-1:0]             lockstep;
	logic [NUM_CH-1:0]             wrReq;
	logic [NUM_CH-1:0][CNT_W-1:0]  wrData;
	logic [NUM_CH-1:0]             clrReq;
	logic [NUM_CH-1:0]             loadEn;
	logic [NUM_CH-1:0][CNT_W-1:0]  loadVal;
	logic [NUM_CH-1:0]             clrEn;

	modport ctl (output lockstep, wrReq, wrData, clrReq, input loadEn, loadVal, clrEn);
	modport fan (input lockstep, wrReq, wrData, clrReq, output loadEn, loadVal, clrEn);
endinterface : tssc_chan_if

`default_nettype wire

//--- logic/tssc_sync_fan.sv
// Purpose: spreads counter writes and clears across lockstep channels
// Assumes: at most one value wins; lowest requesting channel has priority
// Notes:   outputs are registered, one cycle after the request

`timescale 1ns/1ns
`default_nettype none

module tssc_sync_fan
	import tssc_pkg::*;
(
	input  wire logic  sysClk,
	input  wire logic  rstSyncN,
	tssc_chan_if.fan   ch
);
	logic [NUM_CH-1:0]             loadEn_d,  loadEn_q;
	logic [NUM_CH-1:0][CNT_W-1:0]  loadVal_d, loadVal_q;
	logic [NUM_CH-1:0]             clrEn_d,   clrEn_q;
	logic [CNT_W-1:0]              groupVal;
	logic                          groupWr;
	logic                          groupClr;

	// any member of the lockstep group asking
	function automatic logic groupHit(input logic [NUM_CH-1:0] req, input logic [NUM_CH-1:0] grp);
		groupHit = |(req & grp);
	endfunction : groupHit

	// =================================================================
	// next-value logic
	always_comb begin
		groupWr  = groupHit(ch.wrReq, ch.lockstep);
		groupClr = groupHit(ch.clrReq, ch.lockstep);
		groupVal = '0;
		// highest index first so the lowest requester wins
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (ch.wrReq[i] && ch.lockstep[i]) begin
				groupVal = ch.wrData[i];
			end
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (ch.lockstep[i]) begin
				loadEn_d[i]  = groupWr;
				loadVal_d[i] = groupVal;
				clrEn_d[i]   = groupClr;
			end else begin
				loadEn_d[i]  = ch.wrReq[i];
				loadVal_d[i] = ch.wrData[i];
				clrEn_d[i]   = ch.clrReq[i];
			end
		end
	end

	// =================================================================
	// registers
	always_ff @(posedge sysClk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			loadEn_q  <= '0;
			loadVal_q <= '0;
			clrEn_q   <= '0;
		end else begin
			loadEn_q  <= loadEn_d;
			loadVal_q <= loadVal_d;
			clrEn_q   <= clrEn_d;
		end
	end

	assign ch.loadEn  = loadEn_q;
	assign ch.loadVal = loadVal_q;
	assign ch.clrEn   = clrEn_q;

	// =================================================================
	// checks
	default clocking fanClk @(posedge sysClk); endclocking
	default disable iff (!rstSyncN);

	indep_load_a: assert property (ch.wrReq[0] && !ch.lockstep[0]
		|=> ch.loadEn[0] && ch.loadVal[0] == $past(ch.wrData[0]))
		else $error("independent channel 0 write not passed through");
	group_load_a: assert property (groupHit(ch.wrReq, ch.lockstep)
		|=> (ch.loadEn & $past(ch.lockstep)) == $past(ch.lockstep))
		else $error("lockstep write did not load every member");
	group_clear_a: assert property (groupHit(ch.clrReq, ch.lockstep)
		|=> (ch.clrEn & $past(ch.lockstep)) == $past(ch.lockstep))
		else $error("lockstep clear did not reach every member");
	outsider_a: assert property (!ch.lockstep[4] && !ch.wrReq[4]
		|=> !ch.loadEn[4])
		else $error("independent channel 4 loaded by the group");

	group_wr_c: cover property (groupWr && $countones(ch.lockstep) >= 2);
	group_clr_c: cover property (groupClr && ch.lockstep == '1);
endmodule : tssc_sync_fan

`default_nettype wire

//--- logic/tssc_top.sv
// Purpose: run and lockstep control registers for a five-channel timer
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes:   standby forces both registers back to reset value
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.

`timescale 1ns/1ns
`default_nettype none

module tssc_top
	import tssc_pkg::*;
(
	input  wire logic                          sys_clk,
	input  wire logic                          rstn,
	input  wire logic                          standbyReq,
	// register bus
	input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [ADDR_W-1:0]             s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// channel side
	output logic [NUM_CH-1:0]                  runCh,
	output logic [NUM_CH-1:0]                  lockstepCh,
	input  wire logic [NUM_CH-1:0]             cntWrReq,
	input  wire logic [NUM_CH-1:0][CNT_W-1:0]  cntWrData,
	input  wire logic [NUM_CH-1:0]             cntClrReq,
	output logic [NUM_CH-1:0]                  cntLoadEn,
	output logic [NUM_CH-1:0][CNT_W-1:0]       cntLoadVal,
	output logic [NUM_CH-1:0]                  cntClrEn
);
	logic                rstMeta_q;
	logic                rstSyncN;
	logic                awHeld_d, awHeld_q;
	logic [ADDR_W-1:0]   awAddr_d, awAddr_q;
	logic                wHeld_d,  wHeld_q;
	logic [31:0]         wData_d,  wData_q;
	logic [3:0]          wStrb_d,  wStrb_q;
	logic                bValid_d, bValid_q;
	logic [1:0]          bResp_d,  bResp_q;
	logic                rValid_d, rValid_q;
	logic [31:0]         rData_d,  rData_q;
	logic [1:0]          rResp_d,  rResp_q;
	logic [NUM_CH-1:0]   startCtl_d, startCtl_q;
	logic [NUM_CH-1:0]   syncCtl_d,  syncCtl_q;
	logic                doWrite;
	tssc_sel_t           wrSel;
	tssc_sel_t           rdSel;

	tssc_chan_if chIf ();

	// word decode, shared by the write and read paths
	function automatic tssc_sel_t regSel(input logic [ADDR_W-1:0] addr);
		if (addr == OFF_START) begin
			regSel = SEL_START;
		end else if (addr == OFF_SYNC) begin
			regSel = SEL_SYNC;
		end else begin
			regSel = SEL_NONE;
		end
	endfunction : regSel

	// only the low byte lane carries control bits
	function automatic logic s_axi_wstrb_ok(input logic [3:0] strb);
		s_axi_wstrb_ok = strb[0];
	endfunction : s_axi_wstrb_ok

	// =================================================================
	// reset release
	// async assert, sync release so no flop leaves reset on a split edge
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta_q <= 1'b0;
			rstSyncN  <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSyncN  <= rstMeta_q;
		end
	end

	// =================================================================
	// bus slave and control registers, next values
	always_comb begin
		awHeld_d   = awHeld_q;
		awAddr_d   = awAddr_q;
		wHeld_d    = wHeld_q;
		wData_d    = wData_q;
		wStrb_d    = wStrb_q;
		bValid_d   = bValid_q;
		bResp_d    = bResp_q;
		rValid_d   = rValid_q;
		rData_d    = rData_q;
		rResp_d    = rResp_q;
		startCtl_d = startCtl_q;
		syncCtl_d  = syncCtl_q;
		wrSel      = regSel(awAddr_q);
		rdSel      = regSel(s_axi_araddr);
		doWrite    = awHeld_q && wHeld_q && !bValid_q;

		// address and data may arrive in either order
		if (s_axi_awvalid && !awHeld_q) begin
			awHeld_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_q) begin
			wHeld_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (bValid_q && s_axi_bready) begin
			bValid_d = 1'b0;
		end
		if (doWrite) begin
			awHeld_d = 1'b0;
			wHeld_d  = 1'b0;
			bValid_d = 1'b1;
			bResp_d  = (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			if (s_axi_wstrb_ok(wStrb_q) && wrSel == SEL_START) begin
				startCtl_d = wData_q[CH_LSB +: NUM_CH];
			end
			if (s_axi_wstrb_ok(wStrb_q) && wrSel == SEL_SYNC) begin
				syncCtl_d = wData_q[CH_LSB +: NUM_CH];
			end
		end

		// read answers one cycle after address taken
		if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
		if (s_axi_arvalid && !rValid_q) begin
			rValid_d = 1'b1;
			rResp_d  = RESP_OKAY;
			unique case (rdSel)
				SEL_START: rData_d = {24'h00_0000, RSVD_ONES | {3'h0, startCtl_q}};
				SEL_SYNC:  rData_d = {24'h00_0000, RSVD_ONES | {3'h0, syncCtl_q}};
				SEL_NONE: begin
					rData_d = 32'h0000_0000;
					rResp_d = RESP_SLVERR;
				end
			endcase
		end

		if (standbyReq) begin
			startCtl_d = START_RESET[CH_LSB +: NUM_CH];
			syncCtl_d  = SYNC_RESET[CH_LSB +: NUM_CH];
		end
	end

	// =================================================================
	// registers
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			awHeld_q   <= 1'b0;
			awAddr_q   <= '0;
			wHeld_q    <= 1'b0;
			wData_q    <= 32'h0000_0000;
			wStrb_q    <= 4'h0;
			bValid_q   <= 1'b0;
			bResp_q    <= RESP_OKAY;
			rValid_q   <= 1'b0;
			rData_q    <= 32'h0000_0000;
			rResp_q    <= RESP_OKAY;
			startCtl_q <= START_RESET[CH_LSB +: NUM_CH];
			syncCtl_q  <= SYNC_RESET[CH_LSB +: NUM_CH];
		end else begin
			awHeld_q   <= awHeld_d;
			awAddr_q   <= awAddr_d;
			wHeld_q    <= wHeld_d;
			wData_q    <= wData_d;
			wStrb_q    <= wStrb_d;
			bValid_q   <= bValid_d;
			bResp_q    <= bResp_d;
			rValid_q   <= rValid_d;
			rData_q    <= rData_d;
			rResp_q    <= rResp_d;
			startCtl_q <= startCtl_d;
			syncCtl_q  <= syncCtl_d;
		end
	end

	// bus outputs
	assign s_axi_awready = !awHeld_q;
	assign s_axi_wready  = !wHeld_q;
	assign s_axi_bvalid  = bValid_q;
	assign s_axi_bresp   = bResp_q;
	assign s_axi_arready = !rValid_q;
	assign s_axi_rvalid  = rValid_q;
	assign s_axi_rdata   = rData_q;
	assign s_axi_rresp   = rResp_q;

	// =================================================================
	// channel control
	// run bit per counter
	assign runCh      = startCtl_q;
	assign lockstepCh = syncCtl_q;

	assign chIf.lockstep = syncCtl_q;
	assign chIf.wrReq    = cntWrReq;
	assign chIf.wrData   = cntWrData;
	assign chIf.clrReq   = cntClrReq;
	assign cntLoadEn     = chIf.loadEn;
	assign cntLoadVal    = chIf.loadVal;
	assign cntClrEn      = chIf.clrEn;

	tssc_sync_fan tssc_sync_fan_inst (
		.sysClk   (sys_clk),
		.rstSyncN (rstSyncN),
		.ch       (chIf)
	);

	// =================================================================
	// checks
	default clocking topClk @(posedge sys_clk); endclocking
	default disable iff (!rstSyncN);

	standby_start_a: assert property (standbyReq |=> runCh == '0)
		else $error("standby did not halt all counters");
	standby_sync_a: assert property (standbyReq |=> lockstepCh == '0)
		else $error("standby did not clear lockstep bits");
	rsvd_read_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_OKAY
		|-> s_axi_rdata[7:5] == 3'h7 && s_axi_rdata[31:8] == 24'h00_0000)
		else $error("reserved bits not read as one");
	run_write_a: assert property (doWrite && wrSel == SEL_START && wStrb_q[0] && !standbyReq
		|=> runCh == $past(wData_q[4:0]))
		else $error("run bits do not follow the written value");
	sync_write_a: assert property (doWrite && wrSel == SEL_SYNC && wStrb_q[0] && !standbyReq
		|=> lockstepCh == $past(wData_q[4:0]))
		else $error("lockstep bits do not follow the written value");
	run_hold_a: assert property (!(doWrite && wrSel == SEL_START) && !standbyReq
		|=> $stable(runCh))
		else $error("run bits changed without a write");
	reset_indep_a: assert property ($rose(rstSyncN) |-> lockstepCh == '0 && runCh == '0)
		else $error("channels not independent and halted after reset");
	write_resp_a: assert property (awHeld_q && wHeld_q && !bValid_q
		|=> s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write response missing one cycle after both halves");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before accept");

	run_write_c: cover property (doWrite && wrSel == SEL_START && wData_q[4:0] == 5'h1F);
	sync_write_c: cover property (doWrite && wrSel == SEL_SYNC);
	bad_read_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : tssc_top

`default_nettype wire

//--- tb/timer_start_sync_control_bench.sv
// Purpose: self-checking bench for the timer run and lockstep control block
// Assumes: bench acts as bus master and as the five channel counters
// Notes:   design assertions run alongside; bench judges ports only

`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// bench top
module timer_start_sync_control_bench
	import tssc_pkg::*;
;
	logic                          sysClk = 1'b0;
	logic                          rstn = 1'b0;
	logic                          standbyReq = 1'b0;
	logic [ADDR_W-1:0]             awaddr = '0;
	logic                          awvalid = 1'b0;
	logic                          awready;
	logic [31:0]                   wdata = '0;
	logic [3:0]                    wstrb = '0;
	logic                          wvalid = 1'b0;
	logic                          wready;
	logic [1:0]                    bresp;
	logic                          bvalid;
	logic                          bready = 1'b0;
	logic [ADDR_W-1:0]             araddr = '0;
	logic                          arvalid = 1'b0;
	logic                          arready;
	logic [31:0]                   rdata;
	logic [1:0]                    rresp;
	logic                          rvalid;
	logic                          rready = 1'b0;
	logic [NUM_CH-1:0]             runCh;
	logic [NUM_CH-1:0]             lockstepCh;
	logic [NUM_CH-1:0]             cntWrReq = '0;
	logic [NUM_CH-1:0][CNT_W-1:0]  cntWrData = '0;
	logic [NUM_CH-1:0]             cntClrReq = '0;
	logic [NUM_CH-1:0]             cntLoadEn;
	logic [NUM_CH-1:0][CNT_W-1:0]  cntLoadVal;
	logic [NUM_CH-1:0]             cntClrEn;
	int                            errTotal = 0;
	int                            checked = 0;
	logic [1:0]                    resp;
	logic [31:0]                   data;

	// 50 MHz clock
	always #10 sysClk = ~sysClk;

	tssc_top tssc_top_inst (
		.sys_clk(sysClk), .rstn(rstn), .standbyReq(standbyReq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.runCh(runCh), .lockstepCh(lockstepCh), .cntWrReq(cntWrReq), .cntWrData(cntWrData),
		.cntClrReq(cntClrReq), .cntLoadEn(cntLoadEn), .cntLoadVal(cntLoadVal), .cntClrEn(cntClrEn)
	);

	// =================================================================
	// helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// readies are looked at 1 ns after an edge, which is what the next edge samples
	task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aT, wT, bT, done;
		done = 1'b0;
		@(posedge sysClk);
		awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
		while (!done) begin
			#1;
			aT = awvalid && awready;
			wT = wvalid && wready;
			bT = bvalid === 1'b1;
			resp = bresp;
			@(posedge sysClk);
			if (aT) awvalid <= 1'b0;
			if (wT) wvalid <= 1'b0;
			if (bT) begin
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_write

	task axi_read(input logic [7:0] a);
		logic aT, rT, done;
		done = 1'b0;
		@(posedge sysClk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!done) begin
			#1;
			aT = arvalid && arready;
			rT = rvalid === 1'b1;
			data = rdata;
			resp = rresp;
			@(posedge sysClk);
			if (aT) arvalid <= 1'b0;
			if (rT) begin
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_read

	// one-cycle request from the counters, outputs judged one cycle later
	task chan_pulse(input logic [4:0] wr, input logic [4:0] clr);
		@(posedge sysClk);
		cntWrReq <= wr; cntClrReq <= clr;
		@(posedge sysClk);
		cntWrReq <= '0; cntClrReq <= '0;
		#1;
	endtask : chan_pulse

	// =================================================================
	// scenarios
	task test_reset;
		axi_read(OFF_START);
		chk(data, 32'h0000_00E0);
		chk(resp, RESP_OKAY);
		axi_read(OFF_SYNC);
		chk(data, 32'h0000_00E0);
		chk(lockstepCh, 5'h00);
		chk(runCh, 5'h00);
		$display("test reset done");
	endtask : test_reset

	task test_run;
		for (int i = 0; i < NUM_CH; i++) begin
			axi_write(OFF_START, 32'h1 << i, 4'hF);
			chk(runCh, 5'h1 << i);
			axi_read(OFF_START);
			chk(data, 32'h0000_00E0 | (32'h1 << i));
		end
		// reserved bits written as zero must still read one, ones above bit 7 ignored
		axi_write(OFF_START, 32'h0000_0015, 4'h1);
		chk(runCh, 5'h15);
		axi_write(OFF_START, 32'h0000_FF0A, 4'h1);
		chk(runCh, 5'h0A);
		axi_read(OFF_START);
		chk(data, 32'h0000_00EA);
		axi_write(OFF_START, 32'h0000_001F, 4'hE);
		chk(resp, RESP_OKAY);
		chk(runCh, 5'h0A);
		axi_write(OFF_START, 32'h0000_0000, 4'hF);
		chk(runCh, 5'h00);
		$display("test run done");
	endtask : test_run

	task test_sync;
		axi_write(OFF_SYNC, 32'h0000_0003, 4'hF);
		chk(lockstepCh, 5'h03);
		axi_read(OFF_SYNC);
		chk(data, 32'h0000_00E3);
		cntWrData[0] <= 16'h5A5A;
		cntWrData[1] <= 16'h1234;
		cntWrData[3] <= 16'hBEEF;
		chan_pulse(5'h02, 5'h00);
		chk(cntLoadEn, 5'h03);
		chk(cntLoadVal[0], 16'h1234);
		chk(cntLoadVal[1], 16'h1234);
		// two grouped requests at once: lowest channel value wins
		chan_pulse(5'h03, 5'h00);
		chk(cntLoadVal[1], 16'h5A5A);
		chan_pulse(5'h08, 5'h00);
		chk(cntLoadEn, 5'h08);
		chk(cntLoadVal[3], 16'hBEEF);
		chan_pulse(5'h00, 5'h02);
		chk(cntClrEn, 5'h03);
		chan_pulse(5'h00, 5'h10);
		chk(cntClrEn, 5'h10);
		#20;
		chk(cntClrEn, 5'h00);
		$display("test sync done");
	endtask : test_sync

	task test_unmapped;
		axi_write(8'h08, 32'h0000_001F, 4'hF);
		chk(resp, RESP_SLVERR);
		axi_read(8'h08);
		chk(data, 32'h0000_0000);
		chk(resp, RESP_SLVERR);
		chk(runCh, 5'h00);
		$display("test unmapped done");
	endtask : test_unmapped

	task test_standby;
		axi_write(OFF_START, 32'h0000_001F, 4'hF);
		chk(runCh, 5'h1F);
		@(posedge sysClk);
		standbyReq <= 1'b1;
		axi_read(OFF_START);
		chk(data, 32'h0000_00E0);
		axi_read(OFF_SYNC);
		chk(data, 32'h0000_00E0);
		chk(runCh, 5'h00);
		chk(lockstepCh, 5'h00);
		// a write while standby is held must not stick
		axi_write(OFF_SYNC, 32'h0000_001F, 4'hF);
		chk(resp, RESP_OKAY);
		chk(lockstepCh, 5'h00);
		standbyReq <= 1'b0;
		axi_read(OFF_SYNC);
		chk(data, 32'h0000_00E0);
		$display("test standby done");
	endtask : test_standby

	// =================================================================
	// verdict, reached from the sequence end and the watchdog
	task final_report;
		$display("comparisons %0d mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// main sequence, reset held three cycles
	initial begin
		repeat (3) @(posedge sysClk);
		rstn <= 1'b1;
		repeat (3) @(posedge sysClk);
		test_reset();
		test_run();
		test_sync();
		test_unmapped();
		test_standby();
		final_report();
	end

	// watchdog, well beyond the hundred or so cycles the tests need
	initial begin
		repeat (5000) @(posedge sysClk);
		errTotal++;
		final_report();
	end
endmodule : timer_start_sync_control_bench

`default_nettype wire
